// ---- rtl/plb_pkg.sv ----
package plb_pkg;
	// block dimensions
	localparam int NUM_IN     = 36;
	localparam int NUM_MC     = 16;
	localparam int PAL_PER_MC = 5;
	localparam int PLA_TERMS  = 32;
	localparam int NUM_CT     = 6;
	localparam int NUM_GCLK   = 4;
	localparam int NUM_CLKSRC = 6;
	localparam int PLA_BASE   = NUM_MC * PAL_PER_MC;
	localparam int CT_BASE    = PLA_BASE + PLA_TERMS;
	localparam int NUM_TERMS  = CT_BASE + NUM_CT;
	localparam int FB_W       = 2 * NUM_MC;

	// register port
	localparam int ADDR_W = 9;
	localparam int DATA_W = 36;
	localparam logic [8:0] TERM_BASE     = 9'h000;
	localparam logic [8:0] TERM_END      = 9'h0EC;
	localparam logic [8:0] MC_CFG_BASE   = 9'h100;
	localparam logic [8:0] MC_OR_BASE    = 9'h110;
	localparam logic [8:0] CT_MODE_ADDR  = 9'h120;
	localparam logic [8:0] GCLK_CFG_ADDR = 9'h121;
	localparam logic [8:0] STATUS_ADDR   = 9'h122;

	// macrocell config word layout
	localparam int MC_CFG_W    = 10;
	localparam int MODE_LSB    = 0;
	localparam int CLKSEL_LSB  = 2;
	localparam int FALL_BIT    = 5;
	localparam int ARST_EN_BIT = 6;
	localparam int OE_LSB      = 7;

	// global clock config word layout
	localparam int GCLK_CFG_W  = 16;
	localparam int GCLK_FLD_W  = 5;
	localparam int GTS_EN_BIT  = 15;

	typedef enum logic [1:0] {
		PLB_MODE_D,
		PLB_MODE_T,
		PLB_MODE_COMB
	} plb_mode_t;

	// clock source and output enable selector codes
	localparam logic [2:0] CLK_SEL_CT2 = 3'h4;
	localparam logic [2:0] CLK_SEL_CT3 = 3'h5;
	localparam logic [2:0] OE_SEL_ON   = 3'h4;
	localparam logic [2:0] OE_SEL_OFF  = 3'h5;

	// values after reset
	localparam logic [35:0] TERM_MASK_RST = 36'hFFFFFFFFF;
	localparam logic [9:0]  MC_CFG_RST    = 10'h280;
	localparam logic [31:0] MC_OR_RST     = 32'h00000000;
	localparam logic [5:0]  CT_MODE_RST   = 6'h00;
	localparam logic [15:0] GCLK_CFG_RST  = 16'h0000;
endpackage

// ---- rtl/plb_logic_block.sv ----
// Implementation choices: the register offsets and the address-and-strobe port.
module plb_logic_block #(
	parameter int NUM_MC = plb_pkg::NUM_MC
) (
	input  wire logic                        clk_i,
	input  wire logic                        reset_n_i,
	input  wire logic                        ce_i,
	input  wire logic [plb_pkg::NUM_IN-1:0]  interconnect_array_i,
	input  wire logic [3:0]                  global_clock_i,
	input  wire logic                        global_tristate_input_i,
	input  wire logic [NUM_MC-1:0]           pin_i,
	output logic      [NUM_MC-1:0]           pin_o,
	output logic      [NUM_MC-1:0]           pin_oe_n_o,
	output logic      [2*NUM_MC-1:0]         feedback_o,
	input  wire logic [plb_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [plb_pkg::DATA_W-1:0]  wdata_i,
	input  wire logic                        wr_i,
	input  wire logic                        rd_i,
	output logic      [plb_pkg::DATA_W-1:0]  rdata_o
);
	localparam int NT = plb_pkg::NUM_TERMS;
	localparam logic [2:0] CLK_SEL_GLOBALS = 3'h4;

	// configuration store
	logic [35:0]                     term_true_ff [NT];
	logic [35:0]                     term_comp_ff [NT];
	logic [plb_pkg::MC_CFG_W-1:0]    mc_cfg_ff    [NUM_MC];
	logic [31:0]                     mc_or_ff     [NUM_MC];
	logic [5:0]                      ct_mode_ff;
	logic [plb_pkg::GCLK_CFG_W-1:0]  gclk_cfg_ff;

	// logic state
	logic [NUM_MC-1:0]               mc_q_ff;
	logic [NUM_MC-1:0]               nxt_mc_q;
	logic [5:0]                      clk_prev_ff;
	logic [5:0]                      nxt_clk_prev;
	logic [plb_pkg::DATA_W-1:0]      rdata_ff;
	logic [plb_pkg::DATA_W-1:0]      nxt_rdata;

	logic [NT-1:0]                   prod_v;
	logic [NT-1:0]                   sum_v;
	logic [5:0]                      ct;
	logic [NUM_MC-1:0]               mc_d;
	logic [NUM_MC-1:0]               mc_out;
	logic [NUM_MC-1:0]               mc_edge;
	logic [NUM_MC-1:0]               oe;
	logic [3:0]                      gclk_lvl;
	logic [5:0]                      src_lvl;
	logic [5:0]                      src_rise;
	logic [5:0]                      src_fall;
	logic                            gts_active;

	// and/or array: a term with no literal connected is 1 as product, 0 as sum
	always_comb begin
		for (int t = 0; t < NT; t++) begin
			prod_v[t] = &((interconnect_array_i | ~term_true_ff[t]) &
				(~interconnect_array_i | ~term_comp_ff[t]));
			sum_v[t]  = |((interconnect_array_i & term_true_ff[t]) |
				(~interconnect_array_i & term_comp_ff[t]));
		end
	end

	// control terms pick sum or product form
	always_comb begin
		for (int c = 0; c < plb_pkg::NUM_CT; c++) begin
			ct[c] = ct_mode_ff[c] ? sum_v[plb_pkg::CT_BASE+c] : prod_v[plb_pkg::CT_BASE+c];
		end
	end

	// macrocell sum: own pal terms plus any shared pla terms
	always_comb begin
		for (int m = 0; m < NUM_MC; m++) begin
			mc_d[m] = (|prod_v[m*plb_pkg::PAL_PER_MC +: plb_pkg::PAL_PER_MC]) |
				(|(prod_v[plb_pkg::PLA_BASE +: plb_pkg::PLA_TERMS] & mc_or_ff[m]));
			if (plb_pkg::plb_mode_t'(mc_cfg_ff[m][plb_pkg::MODE_LSB +: 2]) == plb_pkg::PLB_MODE_COMB) begin
				mc_out[m] = mc_d[m];
			end else begin
				mc_out[m] = mc_q_ff[m];
			end
		end
	end

	// global clock levels; async sources read macrocell outputs, no comb loop
	// since a flop only changes one cycle after the edge it sees
	always_comb begin
		gclk_lvl[0] = global_clock_i[0];
		for (int k = 1; k < plb_pkg::NUM_GCLK; k++) begin
			if (gclk_cfg_ff[(k-1)*plb_pkg::GCLK_FLD_W]) begin
				gclk_lvl[k] = mc_out[gclk_cfg_ff[(k-1)*plb_pkg::GCLK_FLD_W+1 +: 4]];
			end else begin
				gclk_lvl[k] = global_clock_i[k];
			end
		end
		src_lvl      = {ct[3], ct[2], gclk_lvl};
		src_rise     = src_lvl & ~clk_prev_ff;
		src_fall     = ~src_lvl & clk_prev_ff;
		nxt_clk_prev = src_lvl;
	end

	// per flop clock selection and next state
	always_comb begin
		logic [2:0] sel;
		logic       arst_en;
		sel     = 3'h0;
		arst_en = 1'b0;
		for (int m = 0; m < NUM_MC; m++) begin
			sel     = mc_cfg_ff[m][plb_pkg::CLKSEL_LSB +: 3];
			arst_en = mc_cfg_ff[m][plb_pkg::ARST_EN_BIT];
			if (sel < CLK_SEL_GLOBALS) begin
				mc_edge[m] = mc_cfg_ff[m][plb_pkg::FALL_BIT] ?
					src_fall[sel[1:0]] : src_rise[sel[1:0]];
			end else if (sel == plb_pkg::CLK_SEL_CT2 || sel == plb_pkg::CLK_SEL_CT3) begin
				mc_edge[m] = src_rise[sel];
			end else begin
				mc_edge[m] = 1'b0;
			end
			// reset beats preset when both terms are active
			if (arst_en && ct[1]) begin
				nxt_mc_q[m] = 1'b0;
			end else if (arst_en && ct[0]) begin
				nxt_mc_q[m] = 1'b1;
			end else if (mc_edge[m]) begin
				case (plb_pkg::plb_mode_t'(mc_cfg_ff[m][plb_pkg::MODE_LSB +: 2]))
					plb_pkg::PLB_MODE_D: begin
						nxt_mc_q[m] = mc_d[m];
					end
					plb_pkg::PLB_MODE_T: begin
						nxt_mc_q[m] = mc_q_ff[m] ^ mc_d[m];
					end
					default: begin
						nxt_mc_q[m] = mc_q_ff[m];
					end
				endcase
			end else begin
				nxt_mc_q[m] = mc_q_ff[m];
			end
		end
	end

	// output enables; global tristate overrides every buffer
	always_comb begin
		logic [2:0] osel;
		osel       = 3'h0;
		gts_active = gclk_cfg_ff[plb_pkg::GTS_EN_BIT] && !global_tristate_input_i;
		for (int m = 0; m < NUM_MC; m++) begin
			osel = mc_cfg_ff[m][plb_pkg::OE_LSB +: 3];
			if (osel < plb_pkg::OE_SEL_ON) begin
				oe[m] = ct[2 + osel];
			end else if (osel == plb_pkg::OE_SEL_ON) begin
				oe[m] = 1'b1;
			end else begin
				oe[m] = 1'b0;
			end
			if (gts_active) begin
				oe[m] = 1'b0;
			end
		end
	end

	// pin side and feedback; pin_i is the resolved pad level
	assign pin_o      = mc_out;
	assign pin_oe_n_o = ~oe;
	assign feedback_o = {pin_i, mc_out};
	assign rdata_o    = rdata_ff;

	// read decode, data valid the cycle after the strobe
	always_comb begin
		nxt_rdata = '0;
		if (rd_i) begin
			if (addr_i < plb_pkg::TERM_END) begin
				nxt_rdata = addr_i[0] ? term_comp_ff[addr_i[7:1]] : term_true_ff[addr_i[7:1]];
			end else if (addr_i[8:4] == plb_pkg::MC_CFG_BASE[8:4]) begin
				nxt_rdata = {26'h0000000, mc_cfg_ff[addr_i[3:0]]};
			end else if (addr_i[8:4] == plb_pkg::MC_OR_BASE[8:4]) begin
				nxt_rdata = {4'h0, mc_or_ff[addr_i[3:0]]};
			end else if (addr_i == plb_pkg::CT_MODE_ADDR) begin
				nxt_rdata = {30'h00000000, ct_mode_ff};
			end else if (addr_i == plb_pkg::GCLK_CFG_ADDR) begin
				nxt_rdata = {20'h00000, gclk_cfg_ff};
			end else if (addr_i == plb_pkg::STATUS_ADDR) begin
				nxt_rdata = {4'h0, pin_i, mc_out};
			end
		end
	end

	// state registers; ce low freezes everything
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			mc_q_ff     <= '0;
			clk_prev_ff <= 6'h00;
			rdata_ff    <= '0;
		end else if (ce_i) begin
			mc_q_ff     <= nxt_mc_q;
			clk_prev_ff <= nxt_clk_prev;
			rdata_ff    <= nxt_rdata;
		end
	end

	// configuration writes, kept as a memory written in place
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			for (int t = 0; t < NT; t++) begin
				term_true_ff[t] <= plb_pkg::TERM_MASK_RST;
				term_comp_ff[t] <= plb_pkg::TERM_MASK_RST;
			end
			for (int m = 0; m < NUM_MC; m++) begin
				mc_cfg_ff[m] <= plb_pkg::MC_CFG_RST;
				mc_or_ff[m]  <= plb_pkg::MC_OR_RST;
			end
			ct_mode_ff  <= plb_pkg::CT_MODE_RST;
			gclk_cfg_ff <= plb_pkg::GCLK_CFG_RST;
		end else if (ce_i && wr_i) begin
			if (addr_i < plb_pkg::TERM_END) begin
				if (addr_i[0]) begin
					term_comp_ff[addr_i[7:1]] <= wdata_i;
				end else begin
					term_true_ff[addr_i[7:1]] <= wdata_i;
				end
			end else if (addr_i[8:4] == plb_pkg::MC_CFG_BASE[8:4]) begin
				mc_cfg_ff[addr_i[3:0]] <= wdata_i[plb_pkg::MC_CFG_W-1:0];
			end else if (addr_i[8:4] == plb_pkg::MC_OR_BASE[8:4]) begin
				mc_or_ff[addr_i[3:0]] <= wdata_i[31:0];
			end else if (addr_i == plb_pkg::CT_MODE_ADDR) begin
				ct_mode_ff <= wdata_i[5:0];
			end else if (addr_i == plb_pkg::GCLK_CFG_ADDR) begin
				gclk_cfg_ff <= wdata_i[plb_pkg::GCLK_CFG_W-1:0];
			end
		end
	end

	// checks on macrocell zero, plus block-wide checks on reset, clock enable and global tristate
	logic [1:0] mode0;
	logic [2:0] oesel0;
	assign mode0  = mc_cfg_ff[0][plb_pkg::MODE_LSB +: 2];
	assign oesel0 = mc_cfg_ff[0][plb_pkg::OE_LSB +: 3];

	property p_por_zero;
		@(posedge clk_i) !reset_n_i |=> mc_q_ff == '0;
	endproperty
	a_por_zero: assert property (p_por_zero) else $error("flops not zero after reset");

	property p_dff_rise;
		@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && mode0 == 2'h0 && !mc_cfg_ff[0][plb_pkg::ARST_EN_BIT] &&
		mc_cfg_ff[0][plb_pkg::CLKSEL_LSB +: 3] == 3'h0 && !mc_cfg_ff[0][plb_pkg::FALL_BIT] &&
		global_clock_i[0] && !clk_prev_ff[0] |=> mc_q_ff[0] == $past(mc_d[0]);
	endproperty
	a_dff_rise: assert property (p_dff_rise) else $error("d flop missed rising edge");

	property p_dff_fall;
		@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && mode0 == 2'h0 && !mc_cfg_ff[0][plb_pkg::ARST_EN_BIT] &&
		mc_cfg_ff[0][plb_pkg::CLKSEL_LSB +: 3] == 3'h0 && mc_cfg_ff[0][plb_pkg::FALL_BIT] &&
		!global_clock_i[0] && clk_prev_ff[0] |=> mc_q_ff[0] == $past(mc_d[0]);
	endproperty
	a_dff_fall: assert property (p_dff_fall) else $error("d flop missed falling edge");

	property p_tff_ct2;
		@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && mode0 == 2'h1 && !mc_cfg_ff[0][plb_pkg::ARST_EN_BIT] &&
		mc_cfg_ff[0][plb_pkg::CLKSEL_LSB +: 3] == plb_pkg::CLK_SEL_CT2 && ct[2] && !clk_prev_ff[4]
		|=> mc_q_ff[0] == ($past(mc_q_ff[0]) ^ $past(mc_d[0]));
	endproperty
	a_tff_ct2: assert property (p_tff_ct2) else $error("t flop wrong on term clock");

	property p_comb_bypass;
		@(posedge clk_i) disable iff (!reset_n_i)
		mode0 == 2'h2 |-> pin_o[0] == mc_d[0] && feedback_o[0] == mc_d[0];
	endproperty
	a_comb_bypass: assert property (p_comb_bypass) else $error("bypass not combinational");

	property p_async_reset;
		@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && mc_cfg_ff[0][plb_pkg::ARST_EN_BIT] && ct[1] |=> !mc_q_ff[0];
	endproperty
	a_async_reset: assert property (p_async_reset) else $error("reset term ignored");

	// preset only wins when the reset term is quiet
	property p_async_preset;
		@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && mc_cfg_ff[0][plb_pkg::ARST_EN_BIT] && ct[0] && !ct[1] |=> mc_q_ff[0];
	endproperty
	a_async_preset: assert property (p_async_preset) else $error("preset term ignored");

	// clock enable low must freeze flops and read data
	property p_ce_hold;
		@(posedge clk_i) disable iff (!reset_n_i)
		!ce_i |=> mc_q_ff == $past(mc_q_ff) && rdata_o == $past(rdata_o);
	endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("state moved with enable low");

	property p_arst_off_hold;
		@(posedge clk_i) disable iff (!reset_n_i)
		!mc_cfg_ff[0][plb_pkg::ARST_EN_BIT] && !mc_edge[0] ##1 !$changed(mc_cfg_ff[0])
		|-> mc_q_ff[0] == $past(mc_q_ff[0]);
	endproperty
	a_arst_off_hold: assert property (p_arst_off_hold) else $error("flop moved without edge");

	property p_gts_off;
		@(posedge clk_i) disable iff (!reset_n_i)
		gclk_cfg_ff[plb_pkg::GTS_EN_BIT] && !global_tristate_input_i |-> &pin_oe_n_o;
	endproperty
	a_gts_off: assert property (p_gts_off) else $error("output on under global tristate");

	property p_oe_fixed;
		@(posedge clk_i) disable iff (!reset_n_i)
		(oesel0 == plb_pkg::OE_SEL_OFF |-> pin_oe_n_o[0]) and
		(oesel0 == plb_pkg::OE_SEL_ON && !gts_active |-> !pin_oe_n_o[0]);
	endproperty
	a_oe_fixed: assert property (p_oe_fixed) else $error("fixed enable not honoured");

	c_comb_mode: cover property (@(posedge clk_i) disable iff (!reset_n_i) mode0 == 2'h2 && mc_d[0]);
	c_toggle:    cover property (@(posedge clk_i) disable iff (!reset_n_i)
		mode0 == 2'h1 && mc_edge[0] && mc_d[0]);
	c_gts:       cover property (@(posedge clk_i) disable iff (!reset_n_i) gts_active);
	c_preset:    cover property (@(posedge clk_i) disable iff (!reset_n_i)
		mc_cfg_ff[0][plb_pkg::ARST_EN_BIT] && ct[0]);
	c_async_clk: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		gclk_cfg_ff[0] && src_rise[1]);
endmodule

// ---- dv/plb_pad_model.sv ----
module plb_pad_model (
	input  wire logic        clk_i,
	input  wire logic [15:0] pin_o_i,
	input  wire logic [15:0] oe_n_i,
	input  wire logic [15:0] ext_en_i,
	input  wire logic [15:0] ext_val_i,
	output logic      [15:0] pad_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] last_ff = 16'h0000;
	// pad level: block first, then outside driver, else a floating level
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (!oe_n_i[i]) begin
				pad_o[i] = pin_o_i[i];
			end else if (ext_en_i[i]) begin
				pad_o[i] = ext_val_i[i];
			end else begin
				pad_o[i] = ~last_ff[i]; // no pull: never repeats the last level
			end
		end
	end
	// last level seen, so a released pad drifts away from it
	always_ff @(posedge clk_i) last_ff <= pad_o;
endmodule

// ---- dv/tb.sv ----
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] MD = plb_pkg::PLB_MODE_D;
	localparam logic [1:0] MT = plb_pkg::PLB_MODE_T;
	localparam logic [1:0] MC = plb_pkg::PLB_MODE_COMB;
	localparam logic [2:0] ON = plb_pkg::OE_SEL_ON;
	logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, global_tristate_input = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [35:0] ia = '0, wdata = '0, rdata;
	logic [3:0]  gclk = 4'h0;
	logic [8:0]  addr = 9'h000;
	logic [15:0] pad, pin_o, oe_n, ext_en = 16'h0000, ext_val = 16'h0000;
	logic [31:0] fb;
	int          miscompares = 0, comparisons = 0;

	plb_logic_block u_dut (.clk_i(clk), .reset_n_i(rst_n), .ce_i(ce),
		.interconnect_array_i(ia), .global_clock_i(gclk), .global_tristate_input_i(global_tristate_input),
		.pin_i(pad), .pin_o(pin_o), .pin_oe_n_o(oe_n), .feedback_o(fb), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
	plb_pad_model u_pads (.clk_i(clk), .pin_o_i(pin_o), .oe_n_i(oe_n), .ext_en_i(ext_en),
		.ext_val_i(ext_val), .pad_o(pad));

	// 40 MHz
	initial begin
		forever #12.5 clk = ~clk;
	end

	task conclude;
		if (miscompares == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task chk(input string n, input logic [35:0] got, input logic [35:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, exp, got);
		end
	endtask

	// strobes drop at the next edge, so back to back calls never collide
	task wreg(input logic [8:0] a, input logic [35:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task rchk(input string n, input logic [8:0] a, input logic [35:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(n, rdata, exp);
	endtask

	task term(input int t, input logic [35:0] tru, input logic [35:0] cmp);
		wreg(9'(2 * t), tru);
		wreg(9'(2 * t + 1), cmp);
	endtask

	function automatic logic [35:0] cfg(input logic [1:0] m, input logic [2:0] c,
		input logic f, input logic a, input logic [2:0] o);
		return {26'h0, o, a, f, c, m};
	endfunction

	// three edges cover the one-cycle flop latency after an edge is seen
	task setin(input logic [35:0] v);
		@(posedge clk);
		ia <= v;
		repeat (3) @(posedge clk);
		#1;
	endtask

	task gset(input int k, input logic v);
		@(posedge clk);
		gclk[k] <= v;
		repeat (3) @(posedge clk);
		#1;
	endtask

	task t_reset;
		#1;
		chk("oe_n", oe_n, 36'hFFFF);
		chk("q", pin_o, 36'h0);
		rchk("cfg", 9'h100, 36'h280);
		rchk("term", 9'h000, 36'hFFFFFFFFF);
		rchk("hole", 9'h1FF, 36'h0);
	endtask

	task t_comb;
		term(0, 36'h1, 36'h0);
		term(5, 36'h0, 36'h800000000);
		wreg(9'h100, cfg(MC, 3'h0, 1'b0, 1'b0, ON));
		wreg(9'h101, cfg(MC, 3'h0, 1'b0, 1'b0, ON));
		setin(36'h1);
		chk("comb", pin_o[1:0], 36'h3);
		chk("oe on", oe_n[1:0], 36'h0);
		chk("fb", {fb[16], fb[0]}, 36'h3);
		setin(36'h800000000);
		chk("comb0", pin_o[1:0], 36'h0);
	endtask

	task t_pla;
		term(80, 36'h2, 36'h0);
		wreg(9'h112, 36'h1);
		wreg(9'h113, 36'h1);
		wreg(9'h102, cfg(MC, 3'h0, 1'b0, 1'b0, ON));
		wreg(9'h103, cfg(MC, 3'h0, 1'b0, 1'b0, ON));
		setin(36'h2);
		chk("shared", pin_o[3:2], 36'h3);
		setin(36'h0);
		chk("shared0", pin_o[3:2], 36'h0);
	endtask

	task t_dff;
		term(20, 36'h4, 36'h0);
		wreg(9'h104, cfg(MD, 3'h0, 1'b0, 1'b0, ON));
		setin(36'h4);
		chk("noedge", pin_o[4], 36'h0);
		gset(0, 1'b1);
		chk("rise", pin_o[4], 36'h1);
		setin(36'h0);
		gset(0, 1'b0);
		chk("fall ign", pin_o[4], 36'h1);
		wreg(9'h104, cfg(MD, 3'h0, 1'b1, 1'b0, ON));
		gset(0, 1'b1);
		chk("rise ign", pin_o[4], 36'h1);
		gset(0, 1'b0);
		chk("fall", pin_o[4], 36'h0);
	endtask

	task t_tff;
		term(25, 36'h4, 36'h0);
		wreg(9'h105, cfg(MT, 3'h1, 1'b0, 1'b0, ON));
		setin(36'h4);
		gset(1, 1'b1);
		chk("toggle", pin_o[5], 36'h1);
		setin(36'h0);
		gset(1, 1'b0);
		gset(1, 1'b1);
		chk("hold", pin_o[5], 36'h1);
		setin(36'h4);
		gset(1, 1'b0);
		gset(1, 1'b1);
		chk("toggle2", pin_o[5], 36'h0);
		setin(36'h0);
	endtask

	task t_arst;
		term(112, 36'h8, 36'h0);
		term(113, 36'h10, 36'h0);
		wreg(9'h104, cfg(MD, 3'h0, 1'b1, 1'b1, ON));
		wreg(9'h100, cfg(MC, 3'h0, 1'b0, 1'b1, ON));
		setin(36'h8);
		chk("preset", pin_o[5:4], 36'h1);
		@(posedge clk);
		ce <= 1'b0;
		ia <= 36'h18;
		repeat (3) @(posedge clk);
		#1 chk("ce hold", pin_o[4], 36'h1);
		@(posedge clk);
		ce <= 1'b1;
		setin(36'h18);
		chk("reset", pin_o[5:4], 36'h0);
		setin(36'h0);
	endtask

	task t_oe;
		term(30, 36'h20, 36'h0);
		term(116, 36'hC0, 36'h0);
		wreg(9'h106, cfg(MC, 3'h0, 1'b0, 1'b0, 3'h2));
		setin(36'h60);
		chk("prod oe", oe_n[6], 36'h1);
		wreg(9'h120, 36'h10);
		setin(36'h60);
		chk("sum oe", oe_n[6], 36'h0);
		term(35, 36'h100, 36'h0);
		term(114, 36'h200, 36'h0);
		wreg(9'h107, cfg(MD, plb_pkg::CLK_SEL_CT2, 1'b0, 1'b0, 3'h0));
		setin(36'h100);
		chk("ct global_clock_zero", {oe_n[7], pin_o[7]}, 36'h2);
		setin(36'h300);
		chk("ct global_clock_one", {oe_n[7], pin_o[7]}, 36'h1);
	endtask

	task t_async;
		wreg(9'h121, 36'h1);
		term(45, 36'h400, 36'h0);
		wreg(9'h109, cfg(MD, 3'h1, 1'b0, 1'b0, ON));
		setin(36'h400);
		chk("async0", pin_o[9], 36'h0);
		setin(36'h401);
		chk("async1", pin_o[9], 36'h1);
	endtask

	task t_gts;
		@(posedge clk);
		global_tristate_input <= 1'b0;
		setin(36'h401);
		chk("gts off", oe_n[0], 36'h0);
		wreg(9'h121, 36'h8000);
		setin(36'h401);
		chk("gts", oe_n, 36'hFFFF);
		@(posedge clk);
		global_tristate_input <= 1'b1;
		setin(36'h401);
		chk("gts rel", oe_n[0], 36'h0);
	endtask

	task t_pin_in;
		term(40, 36'h800, 36'h0);
		wreg(9'h108, cfg(MC, 3'h0, 1'b0, 1'b0, plb_pkg::OE_SEL_OFF));
		@(posedge clk);
		ext_en[8] <= 1'b1;
		setin(36'h800);
		chk("in oe", oe_n[8], 36'h1);
		chk("in fb", {fb[24], fb[8]}, 36'h1);
		@(posedge clk);
		ext_val[8] <= 1'b1;
		setin(36'h0);
		chk("in fb2", {fb[24], fb[8]}, 36'h2);
	endtask

	// runaway guard
	initial begin
		#200000;
		miscompares++;
		conclude;
	end

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_comb;
		t_pla;
		t_dff;
		t_tff;
		t_arst;
		t_oe;
		t_async;
		t_gts;
		t_pin_in;
		conclude;
	end
endmodule
